// File: epc_pkg.sv
// Package with register map, field layout and sense encodings for the interrupt block
package epc_pkg;
    // ==========================================
    // Register byte addresses
    localparam logic [7:0] ADDR_SENSE_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_ENABLE_MASK = 8'h04;
    localparam logic [7:0] ADDR_IRQ_FLAGS   = 8'h08;
    localparam logic [7:0] ADDR_GRP_ENABLE  = 8'h0c;
    localparam logic [7:0] ADDR_GRP_FLAGS   = 8'h10;
    localparam logic [7:0] ADDR_GRP0_MASK   = 8'h14;
    localparam logic [7:0] ADDR_GRP1_MASK   = 8'h18;
    localparam logic [7:0] ADDR_GRP2_MASK   = 8'h1c;
    localparam logic [7:0] ADDR_GRP3_MASK   = 8'h20;
    localparam logic [7:0] ADDR_CPU_CTRL    = 8'h24;
    // ==========================================
    // Field layout and reset values
    localparam int         NUM_DED      = 4;
    localparam int         NUM_GRP      = 4;
    localparam int         NUM_PINS     = 27;
    localparam int         GRP_W        = 8;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [7:0] GRP1_MASK_W  = 8'h7f;
    localparam logic [7:0] GRP3_MASK_W  = 8'h07;
    localparam logic [1:0] RESP_OKAY    = 2'b00;
    localparam logic [1:0] RESP_SLVERR  = 2'b10;
    // ==========================================
    // Sense select encodings
    typedef enum logic [1:0] {
        SENSE_LOW  = 2'b00,
        SENSE_ANY  = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } epc_sense_t;
endpackage

// File: epc_irq.sv
// Dedicated and pin-change interrupt detection with AXI4-Lite register slave
`timescale 1ns/1ps
// What this block does
// - Pins sensed regardless of direction; outputs written by software still trigger.
// - Pin-change detection ignores the I/O clock: flags latched on clk_sys, wake path combinational, wakes any sleep.
// - Sense select: 00 low, 01 any change, 10 falling, 11 rising.
// - Low-level mode requests continuously while enabled pin stays low.
// - Low level needs no clock; edge and change modes need the I/O clock.
// - I/O clock stops outside Idle, so edges then go unseen.
// - Low level that vanishes before wake completes wakes but gives no request.
// - Inputs sampled before edge detect; pulses over two clocks always caught.
// - Dedicated request taken only with global enable and its enable bit.
// - Bits 7 to 4 of enable, flag and group enable registers read zero.
// - Dedicated flag sets on triggering edge; clears on vector or written one.
// - Dedicated flag stays cleared while in low-level mode.
// - Group 3 requests on masked change of pins 26..24, vector three.
// - Group 2 requests on masked change of pins 23..16.
// - Group 1 requests on masked change of pins 14..8.
// - Group 0 requests on masked change of pins 7..0.
// - Group 3 flag sets on triggering change; clears on vector or written one.
// - Group flags 2, 1, 0 behave like group 3 flag.
// - Each mask bit enables its own pin; cleared bit excludes it.
module epc_irq (
    input  wire logic                 clk_sys,
    input  wire logic                 resetn,
    input  wire logic [3:0]           dedicatedIrqInputs,
    input  wire logic [26:0]          changeWatchInputs,
    input  wire logic                 ioClockRunning,
    input  wire logic [3:0]           dedVectorAck,
    input  wire logic [3:0]           grpVectorAck,
    output logic      [3:0]           dedRequest,
    output logic      [3:0]           grpRequest,
    output logic                      wakeUp,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready
);
    // ==========================================
    // Registers
    logic [7:0]  senseCtrl_q;
    logic [3:0]  enableMask_q;
    logic [3:0]  dedFlag_q;
    logic [3:0]  grpEnable_q;
    logic [3:0]  grpFlag_q;
    logic [7:0]  grpMask_q [4];
    logic        globalEnable_q;
    logic [7:0]  awAddr_q;
    logic [31:0] wData_q;
    logic        awHave_q;
    logic        wHave_q;
    logic [3:0]  dedClr;
    logic [3:0]  grpClr;
    logic        wrFire;
    logic        wrHit;

    // ==========================================
    // Three-stage input samplers, shared by both input sets
    logic [30:0] pinRaw;
    logic [30:0] sync1_q;
    logic [30:0] sync2_q;
    logic [30:0] sync3_q;
    logic [30:0] stable_q;
    assign pinRaw = {dedicatedIrqInputs, changeWatchInputs};

    // Pin level is read whatever the port direction, so written outputs trigger too
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= '1;                                                // Match stable_q, no false edge
            sync2_q <= '1;
            sync3_q <= '1;
        end else begin
            sync1_q <= pinRaw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // A change is taken once the second and third stages agree
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stable_q <= '1;
        end else begin
            for (int i = 0; i < 31; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    stable_q[i] <= sync3_q[i];
                end
            end
        end
    end

    logic [3:0]  dedNow;
    logic [3:0]  dedPrev_q;
    logic [26:0] pcNow;
    logic [26:0] pcPrev_q;
    assign dedNow = stable_q[30:27];
    assign pcNow  = stable_q[26:0];

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dedPrev_q <= '1;
            pcPrev_q  <= '1;
        end else begin
            dedPrev_q <= dedNow;
            pcPrev_q  <= pcNow;
        end
    end

    // ==========================================
    // Dedicated inputs: edge detect per input
    logic [3:0] dedEdge;
    logic [3:0] dedLevel;
    logic [3:0] lowMode;
    genvar g;
    generate
        for (g = 0; g < epc_pkg::NUM_DED; g++) begin : gDed
            epc_pkg::epc_sense_t sense;
            assign sense = epc_pkg::epc_sense_t'(senseCtrl_q[2*g +: 2]);
            always_comb begin
                dedEdge[g] = 1'b0;
                case (sense)
                    epc_pkg::SENSE_ANY:  dedEdge[g] = dedNow[g] ^ dedPrev_q[g];
                    epc_pkg::SENSE_FALL: dedEdge[g] = dedPrev_q[g] & ~dedNow[g];
                    epc_pkg::SENSE_RISE: dedEdge[g] = ~dedPrev_q[g] & dedNow[g];
                    default:             dedEdge[g] = 1'b0;
                endcase
            end
            // Level term follows the settled pin; no flag is involved
            assign lowMode[g]  = (sense == epc_pkg::SENSE_LOW);
            assign dedLevel[g] = lowMode[g] & ~dedNow[g];
        end
    endgenerate

    // Flags: set wins over a clear in the same cycle; low-level mode holds it at zero
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dedFlag_q <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (senseCtrl_q[2*i +: 2] == epc_pkg::SENSE_LOW) begin
                    dedFlag_q[i] <= 1'b0;
                end else if (dedEdge[i] && ioClockRunning) begin
                    dedFlag_q[i] <= 1'b1;
                end else if (dedClr[i]) begin
                    dedFlag_q[i] <= 1'b0;
                end
            end
        end
    end

    // ==========================================
    // Pin-change groups
    logic [3:0] grpHit;
    generate
        for (g = 0; g < epc_pkg::NUM_GRP; g++) begin : gGrp
            localparam int W = (g == 3) ? 3 : epc_pkg::GRP_W;
            logic [W-1:0] chg;
            assign chg = pcNow[g*8 +: W] ^ pcPrev_q[g*8 +: W];
            assign grpHit[g] = |(chg & grpMask_q[g][W-1:0]);
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            grpFlag_q <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (grpHit[i]) begin
                    grpFlag_q[i] <= 1'b1;
                end else if (grpClr[i]) begin
                    grpFlag_q[i] <= 1'b0;
                end
            end
        end
    end

    // Requests are masked by the group or input enable and the global enable
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            dedRequest[i] = globalEnable_q & enableMask_q[i] & (dedFlag_q[i] | dedLevel[i]);
            grpRequest[i] = globalEnable_q & grpEnable_q[i] & grpFlag_q[i];
        end
    end

    // Wake path needs no clock: raw pins compared combinationally against the last sampled change-pin levels
    logic [26:0] maskFlat;
    assign maskFlat = {grpMask_q[3][2:0], grpMask_q[2], grpMask_q[1], grpMask_q[0]};
    assign wakeUp = |(enableMask_q & ~dedicatedIrqInputs & lowMode)
                  | |(maskFlat & (changeWatchInputs ^ pcPrev_q));

    // ==========================================
    // AXI4-Lite write channel
    assign s_axi_awready = ~awHave_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~wHave_q & ~s_axi_bvalid;
    assign wrFire        = awHave_q & wHave_q & ~s_axi_bvalid;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            awHave_q <= 1'b0;
            wHave_q  <= 1'b0;
            awAddr_q <= '0;
            wData_q  <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end else if (wrFire) begin
                awHave_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
            end else if (wrFire) begin
                wHave_q <= 1'b0;
            end
        end
    end

    logic addrOk;
    always_comb begin
        addrOk = (awAddr_q <= epc_pkg::ADDR_CPU_CTRL) && (awAddr_q[1:0] == 2'b00);
    end
    // Unmapped writes change nothing
    assign wrHit = addrOk;

    // Flag clear strobes by written ones
    assign dedClr = (wrFire && awAddr_q == epc_pkg::ADDR_IRQ_FLAGS) ? wData_q[3:0] | dedVectorAck
                                                                    : dedVectorAck;
    assign grpClr = (wrFire && awAddr_q == epc_pkg::ADDR_GRP_FLAGS) ? wData_q[3:0] | grpVectorAck
                                                                    : grpVectorAck;

    // Control registers; reserved upper bits are never stored
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            senseCtrl_q    <= epc_pkg::RST_BYTE;
            enableMask_q   <= '0;
            grpEnable_q    <= '0;
            globalEnable_q <= 1'b0;
            for (int i = 0; i < 4; i++) grpMask_q[i] <= epc_pkg::RST_BYTE;
        end else if (wrFire && wrHit) begin
            case (awAddr_q)
                epc_pkg::ADDR_SENSE_CTRL:  senseCtrl_q  <= wData_q[7:0];
                epc_pkg::ADDR_ENABLE_MASK: enableMask_q <= wData_q[3:0];
                epc_pkg::ADDR_GRP_ENABLE:  grpEnable_q  <= wData_q[3:0];
                epc_pkg::ADDR_GRP0_MASK:   grpMask_q[0] <= wData_q[7:0];
                epc_pkg::ADDR_GRP1_MASK:   grpMask_q[1] <= wData_q[7:0] & epc_pkg::GRP1_MASK_W;
                epc_pkg::ADDR_GRP2_MASK:   grpMask_q[2] <= wData_q[7:0];
                epc_pkg::ADDR_GRP3_MASK:   grpMask_q[3] <= wData_q[7:0] & epc_pkg::GRP3_MASK_W;
                epc_pkg::ADDR_CPU_CTRL:    globalEnable_q <= wData_q[0];
                default: ;
            endcase
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= epc_pkg::RESP_OKAY;
        end else if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addrOk ? epc_pkg::RESP_OKAY : epc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================
    // AXI4-Lite read channel, one cycle to answer
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= epc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= epc_pkg::RESP_OKAY;
            case (s_axi_araddr)
                epc_pkg::ADDR_SENSE_CTRL:  s_axi_rdata <= {24'h000000, senseCtrl_q};
                epc_pkg::ADDR_ENABLE_MASK: s_axi_rdata <= {28'h0000000, enableMask_q};
                epc_pkg::ADDR_IRQ_FLAGS:   s_axi_rdata <= {28'h0000000, dedFlag_q};
                epc_pkg::ADDR_GRP_ENABLE:  s_axi_rdata <= {28'h0000000, grpEnable_q};
                epc_pkg::ADDR_GRP_FLAGS:   s_axi_rdata <= {28'h0000000, grpFlag_q};
                epc_pkg::ADDR_GRP0_MASK:   s_axi_rdata <= {24'h000000, grpMask_q[0]};
                epc_pkg::ADDR_GRP1_MASK:   s_axi_rdata <= {24'h000000, grpMask_q[1]};
                epc_pkg::ADDR_GRP2_MASK:   s_axi_rdata <= {24'h000000, grpMask_q[2]};
                epc_pkg::ADDR_GRP3_MASK:   s_axi_rdata <= {24'h000000, grpMask_q[3]};
                epc_pkg::ADDR_CPU_CTRL:    s_axi_rdata <= {31'h00000000, globalEnable_q};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= epc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================
    // Checks
    AST_LOWMODE_NOFLAG: assert property (@(posedge clk_sys) disable iff (!resetn)
        (senseCtrl_q[1:0] == epc_pkg::SENSE_LOW) |=> !dedFlag_q[0])
        else $error("flag set in low level mode");
    AST_FALL_SETS: assert property (@(posedge clk_sys) disable iff (!resetn)
        (senseCtrl_q[1:0] == epc_pkg::SENSE_FALL && ioClockRunning && $fell(dedNow[0]))
        |=> dedFlag_q[0])
        else $error("falling edge missed");
    AST_NOCLK_NOFLAG: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!ioClockRunning && !dedFlag_q[0]) |=> !dedFlag_q[0])
        else $error("edge taken without io clock");
    AST_LEVEL_REQ: assert property (@(posedge clk_sys) disable iff (!resetn)
        (globalEnable_q && enableMask_q[1] && dedLevel[1]) |-> dedRequest[1])
        else $error("level request missing");
    AST_GATED: assert property (@(posedge clk_sys) disable iff (!resetn)
        dedRequest[2] |-> globalEnable_q && enableMask_q[2])
        else $error("request without enables");
    AST_GRP2_SET: assert property (@(posedge clk_sys) disable iff (!resetn)
        (grpHit[2]) |=> grpFlag_q[2])
        else $error("group two flag not set");
    AST_GRP3_MASK: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!grpFlag_q[3] && grpMask_q[3] == 8'h00) |=> !grpFlag_q[3])
        else $error("masked pin set group three flag");
    AST_SYNC_DELAY: assert property (@(posedge clk_sys) disable iff (!resetn)
        $changed(stable_q[0]) |-> $past(sync2_q[0]) == $past(sync3_q[0]) && stable_q[0] == $past(sync3_q[0]))
        else $error("unsynchronised change");
    AST_RSV_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_axi_rvalid && $past(s_axi_araddr) == epc_pkg::ADDR_GRP_FLAGS && $rose(s_axi_rvalid)
        |-> s_axi_rdata[7:4] == 4'h0)
        else $error("reserved bits nonzero");
    COV_GRP_REQ: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(grpRequest[0]));
    COV_DED_EDGE: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(dedFlag_q[3]));
    COV_LEVEL: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(dedRequest[0]));
endmodule

// File: epc_pin_src.sv
// Partner model: outside sources that drive the dedicated and pin-change pins
`timescale 1ns/1ps
// ==========================================
// Pin source model
module epc_pin_src (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [3:0]  dedWant,
    input  wire logic [26:0] chgWant,
    output logic      [3:0]  dedicatedIrqInputs,
    output logic      [26:0] changeWatchInputs
);
    // Levels move just after an edge and then stand until asked again, so a
    // low level outlasts any instruction boundary or wake-up time
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dedicatedIrqInputs <= 4'hf;
            changeWatchInputs  <= 27'h0;
        end else begin
            dedicatedIrqInputs <= dedWant;
            changeWatchInputs  <= chgWant;
        end
    end
endmodule

// File: tb_top.sv
// Self-checking bench for the dedicated and pin-change interrupt block
`timescale 1ns/1ps
module tb_top;
    // ==========================================
    // Bench signals and model state
    logic        clk_sys, resetn, ioClk, wakeUp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [3:0]  dedWant, dedPin, pinDed, dedAck, grpAck, dedReq, grpReq, wstrb;
    logic [26:0] chgWant, chgPin, pinChg;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, resp;
    int          n_errors, n_compared, mGlob, mEn, mSense, mFlag, mGEn, mGFlag, nb, b;
    int          mMask [4];
    // ==========================================
    // Clock at 200 MHz
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    epc_pin_src src (.clk_sys(clk_sys), .resetn(resetn), .dedWant(dedWant), .chgWant(chgWant),
        .dedicatedIrqInputs(pinDed), .changeWatchInputs(pinChg));
    epc_irq dut (.clk_sys(clk_sys), .resetn(resetn), .dedicatedIrqInputs(pinDed), .changeWatchInputs(pinChg),
        .ioClockRunning(ioClk), .dedVectorAck(dedAck), .grpVectorAck(grpAck), .dedRequest(dedReq),
        .grpRequest(grpReq), .wakeUp(wakeUp), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // ==========================================
    // Reporting and comparison
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // A wait that runs out counts as a mismatch and closes the run
    task automatic hang;
        n_errors++;
        $display("unexpected timeout at %0t got 0x%h exp 0x%h", $time, 1'b0, 1'b1);
        test_done;
    endtask
    task automatic chkReg(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected reg at %0t got 0x%h exp 0x%h", $time, g, e);
        end
    endtask
    task automatic chkResp(input logic [1:0] g, input logic [1:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected resp at %0t got 0x%h exp 0x%h", $time, g, e);
        end
    endtask
    task automatic chkReq(input logic [3:0] g, input logic [3:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected request at %0t got 0x%h exp 0x%h", $time, g, e);
        end
    endtask
    // ==========================================
    // Bus master; every task leaves one free edge so no signal is set twice at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw, w;
        aw = 0;
        w = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int k = 0; k < 64 && !(aw && w); k++) begin
            @(posedge clk_sys);
            if (awready === 1'b1) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        for (int k = 0; k < 64 && bvalid !== 1'b1; k++) @(posedge clk_sys);
        if (bvalid !== 1'b1) hang;
        resp = bresp;
        bready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rdr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int k = 0; k < 64; k++) begin
            @(posedge clk_sys);
            if (arready === 1'b1) break;
        end
        arvalid <= 1'b0;
        for (int k = 0; k < 64 && rvalid !== 1'b1; k++) @(posedge clk_sys);
        if (rvalid !== 1'b1) hang;
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge clk_sys);
    endtask
    // ==========================================
    // Behavioural model of registers, flags and requests
    function automatic int maskW(input int g);
        return g == 1 ? epc_pkg::GRP1_MASK_W : g == 3 ? epc_pkg::GRP3_MASK_W : 255;
    endfunction
    task automatic setReg(input logic [7:0] a, input int d);
        wr(a, 32'(d));
        chkResp(resp, epc_pkg::RESP_OKAY);
        case (a)
            epc_pkg::ADDR_SENSE_CTRL:  mSense = d & 255;
            epc_pkg::ADDR_ENABLE_MASK: mEn = d & 15;
            epc_pkg::ADDR_IRQ_FLAGS:   mFlag &= ~d;
            epc_pkg::ADDR_GRP_ENABLE:  mGEn = d & 15;
            epc_pkg::ADDR_GRP_FLAGS:   mGFlag &= ~d;
            epc_pkg::ADDR_CPU_CTRL:    mGlob = d & 1;
            default:                   mMask[(a - epc_pkg::ADDR_GRP0_MASK) >> 2] = d & maskW((a - 8'h14) >> 2);
        endcase
    endtask
    function automatic logic [31:0] readExp(input logic [7:0] a);
        case (a)
            epc_pkg::ADDR_SENSE_CTRL:  return mSense;
            epc_pkg::ADDR_ENABLE_MASK: return mEn;
            epc_pkg::ADDR_IRQ_FLAGS:   return mFlag;
            epc_pkg::ADDR_GRP_ENABLE:  return mGEn;
            epc_pkg::ADDR_GRP_FLAGS:   return mGFlag;
            epc_pkg::ADDR_CPU_CTRL:    return mGlob;
            default:                   return mMask[(a - epc_pkg::ADDR_GRP0_MASK) >> 2];
        endcase
    endfunction
    // Low mode requests straight from the pin; edge modes only through the flag
    function automatic logic [3:0] expDed();
        logic [3:0] e;
        for (int i = 0; i < 4; i++) e[i] = mGlob[0] && mEn[i] && (mFlag[i] || ((mSense >> 2 * i) & 3) == 0 && !dedPin[i]);
        return e;
    endfunction
    task automatic verify;
        chkReq(dedReq, expDed());
        chkReq(grpReq, 4'(mGlob ? mGEn & mGFlag : 0));
        rdr(epc_pkg::ADDR_IRQ_FLAGS);
        chkReg(rd, mFlag);
        rdr(epc_pkg::ADDR_GRP_FLAGS);
        chkReg(rd, mGFlag);
    endtask
    task automatic regs;
        for (int a = 0; a < 10; a++) begin
            rdr(8'(a * 4));
            chkReg(rd, readExp(8'(a * 4)));
        end
    endtask
    // Move pins through the partner and step the flag model
    task automatic pins(input logic [3:0] d, input logic [26:0] c, input int hold);
        int m;
        dedWant <= d;
        chgWant <= c;
        for (int i = 0; i < 4; i++) begin
            m = (mSense >> (2 * i)) & 3;
            if (d[i] != dedPin[i] && ioClk && (m == 1 || (m == 2 && !d[i]) || (m == 3 && d[i]))) mFlag |= 1 << i;
        end
        for (int i = 0; i < 27; i++) if (c[i] != chgPin[i] && mMask[i / 8][i % 8]) mGFlag |= 1 << (i / 8);
        dedPin = d;
        chgPin = c;
        repeat (hold) @(posedge clk_sys);
    endtask
    task automatic ack(input logic [3:0] d, input logic [3:0] g);
        dedAck <= d;
        grpAck <= g;
        mFlag &= ~int'(d);
        mGFlag &= ~int'(g);
        @(posedge clk_sys);
        dedAck <= 4'h0;
        grpAck <= 4'h0;
        repeat (2) @(posedge clk_sys);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        {resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {ioClk, dedWant, dedPin, wstrb, chgWant, chgPin, dedAck, grpAck} = {1'b1, 12'hfff, 62'h0};
        {awaddr, araddr, wdata} = '0;
        {mGlob, mEn, mSense, mFlag, mGEn, mGFlag, n_errors, n_compared} = '0;
        mMask = '{default: 0};
        void'($urandom(32'h8788c309));
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        // Reset values, writable widths, then an unmapped place
        regs;
        for (int a = 0; a < 10; a++) setReg(8'(a * 4), -1);
        regs;
        for (int a = 9; a >= 0; a--) setReg(8'(a * 4), 0);
        rdr(8'h40);
        chkResp(resp, epc_pkg::RESP_SLVERR);
        chkReg(rd, 32'h0);
        wr(8'h40, 32'h5a);
        chkResp(resp, epc_pkg::RESP_SLVERR);
        $display("test registers done");
        // Each edge mode on each pin: held edges, a two-cycle pulse, both clears
        setReg(epc_pkg::ADDR_CPU_CTRL, 1);
        for (int n = 0; n < 4; n++) begin
            for (int m = 1; m < 4; m++) begin
                setReg(epc_pkg::ADDR_ENABLE_MASK, 0);
                setReg(epc_pkg::ADDR_SENSE_CTRL, m << (2 * n));
                setReg(epc_pkg::ADDR_ENABLE_MASK, 1 << n);
                pins(4'hf & ~(4'h1 << n), chgPin, 10);
                verify;
                setReg(epc_pkg::ADDR_IRQ_FLAGS, 1 << n);
                pins(4'hf, chgPin, 10);
                verify;
                ack(4'h1 << n, 4'h0);
                pins(4'hf & ~(4'h1 << n), chgPin, 2);
                pins(4'hf, chgPin, 10);
                verify;
                ack(4'h1 << n, 4'h0);
            end
        end
        $display("test edge modes done");
        // Each group: unmasked pin ignored, masked pin flags, then cleared
        setReg(epc_pkg::ADDR_ENABLE_MASK, 0);
        setReg(epc_pkg::ADDR_GRP_ENABLE, 15);
        for (int g = 0; g < 4; g++) begin
            nb = g == 1 ? 7 : g == 3 ? 3 : 8;
            b = $urandom % nb;
            setReg(8'(epc_pkg::ADDR_GRP0_MASK + 4 * g), 1 << b);
            pins(dedPin, chgPin ^ (27'h1 << (g * 8 + (b + 1) % nb)), 10);
            verify;
            pins(dedPin, chgPin ^ (27'h1 << (g * 8 + b)), 10);
            verify;
            if (g % 2) ack(4'h0, 4'h1 << g);
            else setReg(epc_pkg::ADDR_GRP_FLAGS, 1 << g);
            verify;
        end
        $display("test pin groups done");
        // Low level requests without the clock, gated by the global enable
        setReg(epc_pkg::ADDR_SENSE_CTRL, 0);
        setReg(epc_pkg::ADDR_ENABLE_MASK, 15);
        pins(4'h0, chgPin, 10);
        verify;
        chkReq({3'h0, wakeUp}, 4'h1);
        ioClk <= 1'b0;
        @(posedge clk_sys);
        pins(4'h5, chgPin, 10);
        verify;
        setReg(epc_pkg::ADDR_CPU_CTRL, 0);
        verify;
        setReg(epc_pkg::ADDR_CPU_CTRL, 1);
        pins(4'hf, chgPin, 10);
        verify;
        chkReq({3'h0, wakeUp}, 4'h0);
        $display("test low level done");
        // Clock stopped: change mode edge unseen, pin change still flags
        setReg(epc_pkg::ADDR_ENABLE_MASK, 0);
        setReg(epc_pkg::ADDR_SENSE_CTRL, 8'h55);
        setReg(epc_pkg::ADDR_ENABLE_MASK, 15);
        pins(4'he, chgPin ^ (27'h1 << (24 + b)), 10);
        verify;
        $display("test stopped clock done");
        test_done;
    end
endmodule
